// ===== core/dtc_top.sv
// Downstream transport receiver: aligns packets, checks headers, follows
// pointers and hands MAC bytes upward. Software reaches a small register file.
// Assumes RX bytes, FRAME_DONE and the register port are on CLK.
`timescale 1ns/1ps
module dtc_top
  import dtc_pkg::*;
#(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input  wire logic       CLK,
  input  wire logic       NRST,
  // Byte stream from the demodulator
  input  wire logic [7:0] RX_DATA,
  input  wire logic       RX_VALID,
  // MAC byte stream
  output logic      [7:0] MAC_DATA,
  output logic            MAC_VALID,
  output logic            MAC_START,
  input  wire logic       FRAME_DONE,
  // Register port
  input  wire logic [3:0] ADDR,
  input  wire logic [15:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [15:0] RDATA
);
  if (CNT_W < 1 || CNT_W > REG_W) begin : g_chk
    $error("Counter width must lie between 1 and the register width.");
  end

  dtc_if bus ();

  dtc_sync #(
    .LOCK_GOOD (GOOD_TO_LOCK),
    .LOSE_BAD  (BAD_TO_LOSE)
  ) u_sync (
    .clk  (CLK),
    .nrst (NRST),
    .lnk  (bus)
  );

  dtc_hdr u_hdr (
    .clk  (CLK),
    .nrst (NRST),
    .lnk  (bus)
  );

  logic       ctrl_en;
  logic       clr;
  dtc_state_e st;
  logic [7:0] skip;

  assign bus.en = ctrl_en;

  // Input register so the submodules see a clean byte and strobe.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      bus.data  <= 8'h00;
      bus.valid <= 1'b0;
    end else begin
      bus.data  <= RX_DATA;
      bus.valid <= RX_VALID;
    end
  end

  wire pay     = ctrl_en && bus.valid && bus.in_frame && bus.pos >= POS_PTR;
  wire good    = pay && bus.hdr_ok;
  wire at_ptr  = good && bus.pos == POS_PTR && bus.pusi;
  wire ptr_bad = at_ptr && bus.data > PTR_MAX;
  wire stuff   = bus.data == STUFF_BYTE;
  wire body    = good && !at_ptr;
  wire tail    = body && skip != 8'h00 && st == ST_PASS;
  wire fresh   = body && skip == 8'h00 && st == ST_SEEK && !stuff;
  wire carry   = body && skip == 8'h00 && st == ST_PASS;
  wire deliver = tail || fresh || carry;

  // Payload walk: drop until a pointer, skip what it covers, then seek a start.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      st   <= ST_DROP;
      skip <= 8'h00;
    end else if (!bus.in_frame || !ctrl_en) begin
      st   <= ST_DROP;
      skip <= 8'h00;
    end else if (pay) begin
      if (!bus.hdr_ok) begin
        st   <= ST_DROP;
        skip <= 8'h00;
      end else if (at_ptr) begin
        if (ptr_bad) begin
          st   <= ST_DROP;
          skip <= 8'h00;
        end else begin
          skip <= bus.data;
          if (bus.data == 8'h00) st <= ST_SEEK;
        end
      end else if (skip != 8'h00) begin
        skip <= skip - 8'h01;
        if (skip == 8'h01) begin
          st <= ST_SEEK;
        end else if (FRAME_DONE && st == ST_PASS) begin
          st <= ST_DROP;
        end
      end else begin
        case (st)
          ST_SEEK: begin
            if (!stuff) st <= FRAME_DONE ? ST_SEEK : ST_PASS;
          end
          ST_PASS: begin
            if (FRAME_DONE) st <= ST_SEEK;
          end
          default: begin
            st <= ST_DROP;
          end
        endcase
      end
    end else if (FRAME_DONE && st == ST_PASS && skip == 8'h00) begin
      st <= ST_SEEK;
    end
  end

  // MAC side outputs, one registered byte per accepted payload byte.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      MAC_DATA  <= 8'h00;
      MAC_VALID <= 1'b0;
      MAC_START <= 1'b0;
    end else begin
      MAC_VALID <= deliver;
      MAC_START <= fresh;
      if (deliver) MAC_DATA <= bus.data;
    end
  end

  // Control register and the one-cycle counter clear.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ctrl_en <= CTRL_EN_RESET;
      clr     <= 1'b0;
    end else begin
      clr <= WR && ADDR == REG_CTRL && WDATA[CTRL_CLR_BIT];
      if (WR && ADDR == REG_CTRL) ctrl_en <= WDATA[CTRL_EN_BIT];
    end
  end

  // Event counters; an event in the clear cycle counts as the first.
  logic [3:0]       inc;
  logic [CNT_W-1:0] cnt [4];
  assign inc = {ptr_bad,
                bus.hdr_done && bus.cc_err,
                bus.hdr_done && !bus.hdr_ok,
                bus.hdr_done && bus.hdr_ok};
  for (genvar gi = 0; gi < 4; gi++) begin : g_cnt
    // Each counter keeps its own register so every array element has one driver.
    logic [CNT_W-1:0] val;
    always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
        val <= '0;
      end else if (clr) begin
        val <= inc[gi] ? CNT_W'(1) : '0;
      end else if (inc[gi]) begin
        val <= val + CNT_W'(1);
      end
    end
    assign cnt[gi] = val;
  end

  logic [15:0] rd_mux;
  always_comb begin
    case (ADDR)
      REG_CTRL:    rd_mux = {15'h0000, ctrl_en};
      REG_STATUS:  rd_mux = {13'h0000, st == ST_PASS, st == ST_SEEK, bus.in_frame};
      REG_PKT_CNT: rd_mux = 16'(cnt[0]);
      REG_HDR_ERR: rd_mux = 16'(cnt[1]);
      REG_CC_ERR:  rd_mux = 16'(cnt[2]);
      REG_PTR_ERR: rd_mux = 16'(cnt[3]);
      default:     rd_mux = 16'h0000;
    endcase
  end

  // Read data stands only in the cycle after the read strobe.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      RDATA <= 16'h0000;
    end else begin
      RDATA <= RD ? rd_mux : 16'h0000;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  start_not_stuff_a: assert property (MAC_START |-> MAC_VALID && MAC_DATA != STUFF_BYTE)
    else $error("Frame start flagged on a stuff byte.");
  ptr_hidden_a: assert property (at_ptr |=> !MAC_VALID)
    else $error("Pointer byte passed up as payload.");
  hdr_hidden_a: assert property (bus.valid && bus.pos < POS_PTR |=> !MAC_VALID)
    else $error("Header byte passed up as payload.");
  skip_honoured_a: assert property (at_ptr && !ptr_bad && bus.data != 8'h00 && st != ST_PASS
    ##1 (bus.valid && bus.in_frame) |=> !MAC_VALID)
    else $error("Byte covered by the pointer was passed up.");
  unaligned_quiet_a: assert property (!bus.in_frame |=> !MAC_VALID)
    else $error("Payload passed up without packet alignment.");
  start_seen_c: cover property (MAC_START);
  skip_seen_c: cover property (at_ptr && bus.data != 8'h00);
  done_seen_c: cover property (FRAME_DONE && st == ST_PASS);
endmodule : dtc_top

// ===== core/dtc_pkg.sv
// Constants, types and register map of the downstream transport receiver.
// Assumes one 125 MHz clock shared by the demodulator byte stream and software.
// Overview of operation
// - Packets are 188 bytes, 4-byte header
// - First header byte is sync value 0x47
// - Transport error flag set means packet damaged
// - Start indicator set makes byte five the pointer
// - Data packets use identifier 0x1FFE
// - Adaptation control is 01, payload only
// - Four-bit continuity count per data identifier
// - Stuff bytes 0xFF fill gaps, receiver skips
// - Frame control byte never equals 0xFF
// - Pointer counts bytes to skip before seeking
package dtc_pkg;
  localparam int         PKT_LEN       = 188;
  localparam int         HDR_LEN       = 4;
  localparam logic [7:0] POS_LAST      = 8'(PKT_LEN - 1);
  localparam logic [7:0] POS_PTR       = 8'(HDR_LEN);
  localparam logic [7:0] PTR_MAX       = 8'(PKT_LEN - HDR_LEN - 1);
  localparam logic [7:0] SYNC_BYTE     = 8'h47;
  localparam logic [7:0] STUFF_BYTE    = 8'hFF;
  localparam logic [12:0] DATA_PID     = 13'h1FFE;
  localparam logic [1:0] SCRAMBLE_NONE = 2'h0;
  localparam logic [1:0] ADAPT_PAYLOAD = 2'h1;
  localparam int         TEI_BIT       = 7;
  localparam int         PUSI_BIT      = 6;
  localparam int         PRIO_BIT      = 5;
  localparam int         GOOD_TO_LOCK  = 5;
  localparam int         BAD_TO_LOSE   = 9;
  localparam int         REG_W         = 16;
  localparam logic [3:0] REG_CTRL      = 4'h0;
  localparam logic [3:0] REG_STATUS    = 4'h1;
  localparam logic [3:0] REG_PKT_CNT   = 4'h2;
  localparam logic [3:0] REG_HDR_ERR   = 4'h3;
  localparam logic [3:0] REG_CC_ERR    = 4'h4;
  localparam logic [3:0] REG_PTR_ERR   = 4'h5;
  localparam int         CTRL_EN_BIT   = 0;
  localparam int         CTRL_CLR_BIT  = 1;
  localparam logic       CTRL_EN_RESET = 1'b1;
  typedef logic [7:0] dtc_byte_t;
  typedef enum logic [2:0] {
    ST_DROP = 3'b001,
    ST_SEEK = 3'b010,
    ST_PASS = 3'b100
  } dtc_state_e;
endpackage : dtc_pkg

// ===== core/dtc_if.sv
// Carrier between the receiver top and its alignment and header modules.
// Assumes all members change on the one receiver clock.
`timescale 1ns/1ps
interface dtc_if;
  import dtc_pkg::*;
  logic      en;
  dtc_byte_t data;
  logic      valid;
  logic [7:0] pos;
  logic      in_frame;
  logic      hdr_ok;
  logic      pusi;
  logic      cc_err;
  logic      tei;
  logic      hdr_done;
  modport top  (output en, data, valid,
                input  pos, in_frame, hdr_ok, pusi, cc_err, tei, hdr_done);
  modport sync (input  en, data, valid, output pos, in_frame);
  modport hdr  (input  en, data, valid, pos, in_frame,
                output hdr_ok, pusi, cc_err, tei, hdr_done);
endinterface : dtc_if

// ===== core/dtc_sync.sv
// Packet alignment tracker: hunts for the sync byte and keeps the byte position.
// Assumes one byte per valid cycle from the top's input register.
`timescale 1ns/1ps
module dtc_sync
  import dtc_pkg::*;
#(
  parameter int LOCK_GOOD = GOOD_TO_LOCK,
  parameter int LOSE_BAD  = BAD_TO_LOSE
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Stream and alignment
  dtc_if.sync      lnk
);
  localparam logic [3:0] LOCK_N = 4'(LOCK_GOOD);
  localparam logic [3:0] LOSE_N = 4'(LOSE_BAD);
  if (LOCK_GOOD < 2 || LOCK_GOOD > 15 || LOSE_BAD < 2 || LOSE_BAD > 15) begin : g_chk
    $error("Sync thresholds must lie between 2 and 15.");
  end

  logic       cand;
  logic [3:0] good;
  logic [3:0] bad;
  wire        is_sync = lnk.data == SYNC_BYTE;

  // A candidate starts on any sync byte; each later packet start is checked.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cand         <= 1'b0;
      good         <= 4'h0;
      bad          <= 4'h0;
      lnk.pos      <= 8'h00;
      lnk.in_frame <= 1'b0;
    end else if (!lnk.en) begin
      cand         <= 1'b0;
      good         <= 4'h0;
      bad          <= 4'h0;
      lnk.pos      <= 8'h00;
      lnk.in_frame <= 1'b0;
    end else if (lnk.valid) begin
      if (!cand) begin
        if (is_sync) begin
          cand    <= 1'b1;
          good    <= 4'h1;
          lnk.pos <= 8'h01;
        end
      end else if (lnk.pos == 8'h00) begin
        if (is_sync) begin
          bad     <= 4'h0;
          lnk.pos <= 8'h01;
          if (good != LOCK_N) good <= good + 4'h1;
          if (good + 4'h1 >= LOCK_N) lnk.in_frame <= 1'b1;
        end else if (!lnk.in_frame || bad + 4'h1 >= LOSE_N) begin
          cand         <= 1'b0;
          good         <= 4'h0;
          bad          <= 4'h0;
          lnk.pos      <= 8'h00;
          lnk.in_frame <= 1'b0;
        end else begin
          bad     <= bad + 4'h1;
          lnk.pos <= 8'h01;
        end
      end else begin
        lnk.pos <= (lnk.pos == POS_LAST) ? 8'h00 : lnk.pos + 8'h01;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  lock_on_sync_a: assert property ($rose(lnk.in_frame) |->
    $past(lnk.valid && lnk.pos == 8'h00 && is_sync) && $past(good) == LOCK_N - 4'h1)
    else $error("Alignment declared without enough good sync bytes.");
  lose_on_bad_a: assert property ($fell(lnk.in_frame) && $past(lnk.en) |->
    $past(!is_sync && lnk.valid) && $past(bad) == LOSE_N - 4'h1)
    else $error("Alignment lost after the wrong number of bad sync bytes.");
  pos_wrap_a: assert property (lnk.en && lnk.valid && cand && lnk.pos == POS_LAST
    |=> lnk.pos == 8'h00)
    else $error("Byte position did not wrap after the last packet byte.");
  lock_seen_c: cover property ($rose(lnk.in_frame));
  lose_seen_c: cover property ($fell(lnk.in_frame) && $past(lnk.en));
endmodule : dtc_sync

// ===== core/dtc_hdr.sv
// Header checker: gathers header bytes two to four and judges each packet.
// Assumes the alignment tracker supplies the byte position.
`timescale 1ns/1ps
module dtc_hdr
  import dtc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Stream and header verdict
  dtc_if.hdr       lnk
);
  dtc_byte_t  b1;
  dtc_byte_t  b2;
  logic [3:0] last_cc;
  logic       have_cc;
  wire        take    = lnk.en && lnk.valid && lnk.in_frame;
  wire [12:0] pid     = {b1[4:0], b2};
  wire [3:0]  cc      = lnk.data[3:0];
  wire        pid_hit = pid == DATA_PID;
  wire        fields_ok = !b1[TEI_BIT] && !b1[PRIO_BIT] && pid_hit
                          && lnk.data[7:6] == SCRAMBLE_NONE
                          && lnk.data[5:4] == ADAPT_PAYLOAD;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      b1 <= 8'h00;
      b2 <= 8'h00;
    end else if (take && lnk.pos == 8'h01) begin
      b1 <= lnk.data;
    end else if (take && lnk.pos == 8'h02) begin
      b2 <= lnk.data;
    end
  end

  // The verdict is posted on the last header byte and holds for the payload.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lnk.hdr_ok   <= 1'b0;
      lnk.pusi     <= 1'b0;
      lnk.tei      <= 1'b0;
      lnk.cc_err   <= 1'b0;
      lnk.hdr_done <= 1'b0;
      last_cc      <= 4'h0;
      have_cc      <= 1'b0;
    end else begin
      lnk.hdr_done <= take && lnk.pos == 8'h03;
      if (!lnk.in_frame || !lnk.en) begin
        have_cc    <= 1'b0;
        lnk.hdr_ok <= 1'b0;
      end else if (take && lnk.pos == 8'h03) begin
        lnk.hdr_ok <= fields_ok;
        lnk.pusi   <= b1[PUSI_BIT];
        lnk.tei    <= b1[TEI_BIT];
        lnk.cc_err <= pid_hit && have_cc && cc != last_cc + 4'h1;
        if (pid_hit) begin
          last_cc <= cc;
          have_cc <= 1'b1;
        end
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  pid_match_a: assert property (lnk.hdr_done && lnk.hdr_ok |-> pid == DATA_PID)
    else $error("Header accepted on a foreign identifier.");
  error_flag_a: assert property (lnk.hdr_done && lnk.tei |-> !lnk.hdr_ok)
    else $error("Header accepted with the transport error flag set.");
endmodule : dtc_hdr

// ===== tb/dtc_src.sv
// Transport packet source standing in for the demodulator logic.
// Assumes the receiver samples RX_DATA and RX_VALID on the rising clk edge.
`timescale 1ns/1ps
module dtc_src
  import dtc_pkg::*;
(
  // Clock
  input  wire logic clk,
  // Byte stream
  output logic [7:0] rx_data,
  output logic       rx_valid
);
  logic [3:0] cc = 4'h0;
  initial begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
  end
  // Sends one packet; x0, x1 and x3 flip header bits and skip jumps the count.
  task automatic send(input logic pu, input logic [7:0] ptr, input logic [7:0] x0,
                      input logic [7:0] x1, input logic [7:0] x3, input logic skip);
    logic [7:0] b;
    cc = cc + {3'h0, skip};
    for (int p = 0; p < PKT_LEN; p++) begin
      if (p == 0) b = SYNC_BYTE ^ x0;
      else if (p == 1) b = {1'b0, pu, 1'b0, DATA_PID[12:8]} ^ x1;
      else if (p == 2) b = DATA_PID[7:0];
      else if (p == 3) b = {SCRAMBLE_NONE, ADAPT_PAYLOAD, cc} ^ x3;
      else if (pu && p == 4) b = ptr;
      else if (pu && p < 5 + ptr) b = 8'hAA;
      else if (pu && p < 7 + ptr) b = STUFF_BYTE;
      else b = 8'(p) & 8'h3F;
      @(posedge clk);
      rx_data <= b;
      rx_valid <= 1'b1;
    end
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_data <= ~b;
    cc = cc + 4'h1;
  endtask : send
endmodule : dtc_src

// ===== tb/tb.sv
// Self-checking bench for the downstream transport receiver.
// Assumes the packet source model and the register port of dtc_top.
`timescale 1ns/1ps
module tb;
  import dtc_pkg::*;
  logic        CLK = 1'b0;
  logic        NRST = 1'b0;
  wire  [7:0]  RX_DATA;
  wire         RX_VALID;
  logic [7:0]  MAC_DATA;
  logic        MAC_VALID;
  logic        MAC_START;
  logic        FRAME_DONE = 1'b0;
  logic [3:0]  ADDR = 4'h0;
  logic [15:0] WDATA = 16'h0000;
  logic        WR = 1'b0;
  logic        RD = 1'b0;
  logic [15:0] RDATA;
  int          errors = 0;
  int          comparisons = 0;
  int          cyc = 0;
  logic [31:0] n_mac = 32'h0;
  logic [7:0]  first = 8'h00;
  logic [15:0] v;
  logic [15:0] c0;
  logic [15:0] bad [4] = '{16'h8000, 16'h2000, 16'h0040, 16'h0030};
  always #4 CLK = ~CLK;
  dtc_src src (.clk(CLK), .rx_data(RX_DATA), .rx_valid(RX_VALID));
  dtc_top uut (
    .CLK(CLK), .NRST(NRST), .RX_DATA(RX_DATA), .RX_VALID(RX_VALID),
    .MAC_DATA(MAC_DATA), .MAC_VALID(MAC_VALID), .MAC_START(MAC_START),
    .FRAME_DONE(FRAME_DONE), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA)
  );
  always @(posedge CLK) begin
    if (MAC_VALID === 1'b1) n_mac <= n_mac + 32'h1;
    if (MAC_START === 1'b1) first <= MAC_DATA;
  end
  task automatic give_verdict;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 15000) begin
      errors = errors + 1;
      give_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1;
    v = RDATA;
  endtask : rd
  task automatic rc(input logic [3:0] a, input logic [15:0] exp);
    rd(a);
    chk({16'h0, v}, {16'h0, exp});
  endtask : rc
  // Sends a packet and counts the MAC bytes that it yields.
  task automatic pk(input logic pu, input logic [7:0] ptr, input logic [7:0] x0,
                    input logic [15:0] x13, input logic skip, input int exp);
    logic [31:0] m;
    m = n_mac;
    src.send(pu, ptr, x0, x13[15:8], x13[7:0], skip);
    repeat (4) @(posedge CLK);
    #1;
    chk(n_mac - m, exp);
  endtask : pk
  task automatic done;
    @(posedge CLK);
    FRAME_DONE <= 1'b1;
    @(posedge CLK);
    FRAME_DONE <= 1'b0;
  endtask : done
  initial begin
    repeat (4) @(posedge CLK);
    NRST <= 1'b1;
    @(posedge CLK);
    rc(REG_CTRL, 16'h0001);
    rc(REG_STATUS, 16'h0000);
    rc(REG_PKT_CNT, 16'h0000);
    wr(4'hF, 16'hFFFF);
    rc(4'hF, 16'h0000);
    rc(REG_CTRL, 16'h0001);
    for (int i = 0; i < 4; i++) pk(1'b0, 8'h00, 8'h00, 16'h0000, 1'b0, 0);
    rc(REG_STATUS, 16'h0000);
    pk(1'b0, 8'h00, 8'h00, 16'h0000, 1'b0, 0);
    rc(REG_STATUS, 16'h0001);
    rd(REG_PKT_CNT);
    c0 = v;
    pk(1'b1, 8'h03, 8'h00, 16'h0000, 1'b0, 178);
    chk({24'h0, first}, 32'h0A);
    rc(REG_STATUS, 16'h0005);
    pk(1'b0, 8'h00, 8'h00, 16'h0000, 1'b0, 184);
    done();
    rc(REG_STATUS, 16'h0003);
    pk(1'b1, 8'h00, 8'h00, 16'h0000, 1'b0, 181);
    chk({24'h0, first}, 32'h07);
    pk(1'b1, 8'h03, 8'h00, 16'h0000, 1'b0, 181);
    chk({24'h0, first}, 32'h0A);
    rc(REG_PKT_CNT, c0 + 16'h0004);
    rd(REG_HDR_ERR);
    c0 = v;
    for (int i = 0; i < 4; i++) pk(1'b1, 8'h00, 8'h00, bad[i], 1'b0, 0);
    rc(REG_HDR_ERR, c0 + 16'h0004);
    pk(1'b1, 8'h00, 8'h00, 16'h0100, 1'b0, 0);
    pk(1'b1, 8'h00, 8'h00, 16'h0000, 1'b0, 181);
    rd(REG_CC_ERR);
    c0 = v;
    pk(1'b0, 8'h00, 8'h00, 16'h0000, 1'b1, 184);
    pk(1'b0, 8'h00, 8'h00, 16'h0000, 1'b0, 184);
    rc(REG_CC_ERR, c0 + 16'h0001);
    done();
    pk(1'b1, 8'hB8, 8'h00, 16'h0000, 1'b0, 0);
    pk(1'b0, 8'h00, 8'h00, 16'h0000, 1'b0, 0);
    rc(REG_PTR_ERR, 16'h0001);
    wr(REG_CTRL, 16'h0003);
    rc(REG_HDR_ERR, 16'h0000);
    rc(REG_CTRL, 16'h0001);
    for (int i = 0; i < 8; i++) pk(1'b0, 8'h00, 8'h01, 16'h0000, 1'b0, 0);
    rd(REG_STATUS);
    chk({31'h0, v[0]}, 32'h1);
    pk(1'b0, 8'h00, 8'h01, 16'h0000, 1'b0, 0);
    rd(REG_STATUS);
    chk({31'h0, v[0]}, 32'h0);
    for (int i = 0; i < 4; i++) pk(1'b0, 8'h00, 8'h00, 16'h0000, 1'b0, 0);
    rd(REG_STATUS);
    chk({31'h0, v[0]}, 32'h0);
    pk(1'b0, 8'h00, 8'h00, 16'h0000, 1'b0, 0);
    rd(REG_STATUS);
    chk({31'h0, v[0]}, 32'h1);
    wr(REG_CTRL, 16'h0000);
    rc(REG_CTRL, 16'h0000);
    rc(REG_STATUS, 16'h0000);
    pk(1'b1, 8'h00, 8'h00, 16'h0000, 1'b0, 0);
    give_verdict();
  end
endmodule : tb
